// *** shared/hcr_pkg.sv ***
package hcr_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int PTR_W = 8;
  localparam int DATA_W = 16;
  localparam int SN_W = 40;

  // ==========================================================
  // Pointer values
  // ==========================================================
  localparam logic [7:0] ADDR_TEMP = 8'h00;
  localparam logic [7:0] ADDR_HUM = 8'h01;
  localparam logic [7:0] ADDR_CFG = 8'h02;
  localparam logic [7:0] ADDR_SN_HI = 8'hFB;
  localparam logic [7:0] ADDR_SN_MID = 8'hFC;
  localparam logic [7:0] ADDR_SN_LO = 8'hFD;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // ==========================================================
  // Configuration register fields and reset value
  // ==========================================================
  localparam int CFG_RST_BIT = 15;
  localparam int CFG_HEAT_BIT = 13;
  localparam int CFG_MODE_BIT = 12;
  localparam int CFG_LOWSUP_BIT = 11;
  localparam int CFG_TEMP_RESOLUTION_SEL_BIT = 10;
  localparam int CFG_HUMIDITY_RESOLUTION_SEL_LSB = 8;
  localparam logic [15:0] CFG_RESET = 16'h1000;

  // Serial number placement in the low identification word.
  localparam int SN_LO_LSB = 8;

  // Serial number default; the value is arbitrary.
  localparam logic [39:0] SN_DEFAULT = 40'h5A_A512_3C7E;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic soft_rst;
    logic rsvd14;
    logic heater;
    logic acq_both;
    logic low_supply_flag;
    logic temp_resolution_sel;
    logic [1:0] humidity_resolution_sel;
    logic [7:0] rsvd_low;
  } hcr_cfg_t;

  typedef struct packed {
    logic start;
    logic is_hum;
    logic [1:0] res;
  } hcr_conv_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TEMP = 2'b01,
    ST_HUM = 2'b10
  } hcr_state_t;

endpackage

// *** hdl/hcr_regs.sv ***
`timescale 1ns/1ps
// Behaviour
// - The configuration register sits at pointer 0x02 and both sets options and reports status.
// - Writing 1 to configuration bit 15 resets the logic, and that bit always reads back 0.
// - With mode bit 12 at 0 a trigger converts only the quantity that the trigger pointer names.
// - With mode bit 12 at 1 a trigger converts temperature and then humidity.
// - Bit 11 is a read-only low-supply flag that reads 1 when the supply is under threshold.
// - A read-only 40-bit per-part serial number is held in three identification registers.
// - Identification register 0xFB returns serial bits 39 to 24 and is read-only.
// - Identification register 0xFC returns serial bits 23 to 8 and is read-only.
// - Identification register 0xFD returns serial bits 7 to 0 in its upper field, read-only.
// - Bits 6 to 0 of identification register 0xFD always read zero and cannot be written.
// - Bit 10 selects 14-bit temperature conversion at 0 and 11-bit at 1.
// - Bits 9:8 select 14-bit humidity conversion at 00, 11-bit at 01 and 8-bit at 10.
// - Every pointer write loads the 8-bit pointer, and reads come from the last pointer written.
// - The configuration register resets to 0x1000.
module hcr_regs #(
  parameter logic [39:0] SERIAL_NUM = hcr_pkg::SN_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port from the two-wire protocol engine
  input wire logic ptr_wr,
  input wire logic [hcr_pkg::PTR_W-1:0] ptr_in,
  input wire logic data_wr,
  input wire logic [hcr_pkg::DATA_W-1:0] wdata,
  input wire logic rd_req,
  output logic [hcr_pkg::DATA_W-1:0] rd_data_r,
  output logic rd_valid_r,
  output logic nack_r,
  // Supply comparator pin
  input wire logic low_supply_pin,
  // Converter control
  input wire logic conv_done,
  output hcr_pkg::hcr_conv_t conv_r,
  output logic busy_r,
  output logic heater_en_r,
  output logic soft_rst_r
);
  import hcr_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [PTR_W-1:0] ptr_r, ptr_nxt;
  hcr_cfg_t cfg_r, cfg_nxt;
  logic [DATA_W-1:0] rd_data_nxt;
  logic rd_valid_nxt, nack_nxt, soft_rst_nxt, heater_en_nxt;
  logic low_meta_r, low_sync_r;
  hcr_state_t state_r, state_nxt;
  hcr_conv_t conv_nxt;
  logic both_r, both_nxt, busy_nxt;
  logic srst_req, trigger, ptr_mapped, ptr_ro;

  // ==========================================================
  // Supply flag synchroniser
  // ==========================================================
  // The comparator pin is asynchronous, so it passes two flops.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_meta_r <= 1'b0;
      low_sync_r <= 1'b0;
    end else begin
      low_meta_r <= low_supply_pin;
      low_sync_r <= low_meta_r;
    end
  end

  // ==========================================================
  // Register decode
  // ==========================================================
  // Writes of the configuration word with bit 15 set restart the logic.
  assign srst_req = data_wr && (ptr_r == ADDR_CFG) && wdata[CFG_RST_BIT];
  // A pointer write naming a result register starts an acquisition.
  assign trigger = ptr_wr && ((ptr_in == ADDR_TEMP) || (ptr_in == ADDR_HUM));
  // Pointers 0x03 to 0xFA answer nothing.
  assign ptr_mapped = (ptr_in <= ADDR_CFG) || (ptr_in >= ADDR_SN_HI);
  // Everything but the configuration word refuses data.
  assign ptr_ro = (ptr_r != ADDR_CFG);

  // Read multiplexer for the pointed register.
  function automatic logic [DATA_W-1:0] rd_mux(input logic [PTR_W-1:0] p,
                                               input hcr_cfg_t c,
                                               input logic low);
    logic [DATA_W-1:0] v;
    v = 16'h0000;
    unique case (p)
      ADDR_CFG: begin
        v = c;
        v[CFG_LOWSUP_BIT] = low;
        v[CFG_RST_BIT] = 1'b0;
      end
      ADDR_SN_HI: v = SERIAL_NUM[39:24];
      ADDR_SN_MID: v = SERIAL_NUM[23:8];
      ADDR_SN_LO: v = {SERIAL_NUM[7:0], 8'h00};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Pointer, configuration and read path next values.
  always_comb begin
    ptr_nxt = ptr_r;
    cfg_nxt = cfg_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    nack_nxt = 1'b0;
    soft_rst_nxt = 1'b0;
    if (srst_req) begin
      ptr_nxt = PTR_RESET;
      cfg_nxt = CFG_RESET;
      soft_rst_nxt = 1'b1;
    end else begin
      if (ptr_wr) begin
        ptr_nxt = ptr_in;
        nack_nxt = !ptr_mapped;
      end
      if (data_wr) begin
        if (ptr_ro) begin
          nack_nxt = 1'b1;
        end else begin
          cfg_nxt.heater = wdata[CFG_HEAT_BIT];
          cfg_nxt.acq_both = wdata[CFG_MODE_BIT];
          cfg_nxt.temp_resolution_sel = wdata[CFG_TEMP_RESOLUTION_SEL_BIT];
          cfg_nxt.humidity_resolution_sel = wdata[CFG_HUMIDITY_RESOLUTION_SEL_LSB+:2];
        end
      end
      if (rd_req && (ptr_r == ADDR_CFG || ptr_r >= ADDR_SN_HI)) begin
        rd_data_nxt = rd_mux(ptr_r, cfg_r, low_sync_r);
        rd_valid_nxt = 1'b1;
      end
    end
    // Status and reserved bits are never stored.
    cfg_nxt.soft_rst = 1'b0;
    cfg_nxt.low_supply_flag = 1'b0;
    cfg_nxt.rsvd14 = 1'b0;
    cfg_nxt.rsvd_low = 8'h00;
    heater_en_nxt = cfg_nxt.heater;
  end

  // Registers of the pointer, configuration and read path.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_r <= PTR_RESET;
      cfg_r <= CFG_RESET;
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
      nack_r <= 1'b0;
      soft_rst_r <= 1'b0;
      heater_en_r <= 1'b0;
    end else begin
      ptr_r <= ptr_nxt;
      cfg_r <= cfg_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      nack_r <= nack_nxt;
      soft_rst_r <= soft_rst_nxt;
      heater_en_r <= heater_en_nxt;
    end
  end

  // ==========================================================
  // Acquisition sequencer
  // ==========================================================
  // A new trigger aborts any conversion in flight and starts over.
  always_comb begin
    state_nxt = state_r;
    both_nxt = both_r;
    conv_nxt = conv_r;
    conv_nxt.start = 1'b0;
    if (srst_req) begin
      state_nxt = ST_IDLE;
      both_nxt = 1'b0;
    end else if (trigger) begin
      both_nxt = cfg_r.acq_both;
      conv_nxt.start = 1'b1;
      if (cfg_r.acq_both || ptr_in == ADDR_TEMP) begin
        state_nxt = ST_TEMP;
        conv_nxt.is_hum = 1'b0;
        conv_nxt.res = {1'b0, cfg_r.temp_resolution_sel};
      end else begin
        state_nxt = ST_HUM;
        conv_nxt.is_hum = 1'b1;
        conv_nxt.res = cfg_r.humidity_resolution_sel;
      end
    end else begin
      unique case (state_r)
        ST_IDLE: state_nxt = ST_IDLE;
        ST_TEMP: begin
          if (conv_done && both_r) begin
            state_nxt = ST_HUM;
            conv_nxt.start = 1'b1;
            conv_nxt.is_hum = 1'b1;
            conv_nxt.res = cfg_r.humidity_resolution_sel;
          end else if (conv_done) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_HUM: begin
          if (conv_done) begin
            state_nxt = ST_IDLE;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
    busy_nxt = (state_nxt != ST_IDLE);
  end

  // Registers of the sequencer.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      both_r <= 1'b0;
      conv_r <= '0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      both_r <= both_nxt;
      conv_r <= conv_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_soft_reset_restores: assert property (
    srst_req |=> (cfg_r == CFG_RESET) && (ptr_r == PTR_RESET) && soft_rst_r
      ##1 !soft_rst_r)
    else $error("soft reset did not restore defaults");

  a_single_mode_pick: assert property (
    (trigger && !cfg_r.acq_both && !srst_req) |=>
      conv_r.start && (conv_r.is_hum == ($past(ptr_in) == ADDR_HUM)))
    else $error("single acquisition picked wrong quantity");

  a_both_temp_first: assert property (
    (trigger && cfg_r.acq_both && !srst_req) |=>
      conv_r.start && !conv_r.is_hum && state_r == ST_TEMP)
    else $error("combined acquisition did not start with temperature");

  a_low_flag_read: assert property (
    (rd_req && ptr_r == ADDR_CFG && !srst_req) |=>
      rd_valid_r && rd_data_r[CFG_LOWSUP_BIT] == $past(low_sync_r)
      && !rd_data_r[CFG_RST_BIT])
    else $error("configuration read shows wrong status");

  a_ro_write_nack: assert property (
    (data_wr && ptr_r >= ADDR_SN_HI) |=> nack_r && $stable(cfg_r))
    else $error("identification write not refused");

  a_sn_high_word: assert property (
    (rd_req && ptr_r == ADDR_SN_HI) |=> rd_data_r == SERIAL_NUM[39:24])
    else $error("high serial word wrong");

  a_sn_mid_word: assert property (
    (rd_req && ptr_r == ADDR_SN_MID) |=> rd_data_r == SERIAL_NUM[23:8])
    else $error("mid serial word wrong");

  a_sn_low_word: assert property (
    (rd_req && ptr_r == ADDR_SN_LO) |=>
      rd_data_r[15:SN_LO_LSB] == SERIAL_NUM[7:0])
    else $error("low serial byte wrong");

  a_sn_low_zero: assert property (
    (rd_req && ptr_r == ADDR_SN_LO) |=> rd_data_r[6:0] == 7'h00)
    else $error("low serial reserved bits not zero");

  a_temp_res_map: assert property (
    (conv_r.start && !conv_r.is_hum) |->
      conv_r.res == {1'b0, $past(cfg_r.temp_resolution_sel)})
    else $error("temperature resolution not applied");

  a_hum_res_map: assert property (
    (conv_r.start && conv_r.is_hum) |->
      conv_r.res == $past(cfg_r.humidity_resolution_sel))
    else $error("humidity resolution not applied");

  a_both_hum_next: assert property (
    (state_r == ST_TEMP && both_r && conv_done && !trigger && !srst_req)
      |=> conv_r.start && conv_r.is_hum && state_r == ST_HUM)
    else $error("combined acquisition skipped humidity");

  a_cfg_store: assert property (
    (data_wr && ptr_r == ADDR_CFG && !wdata[CFG_RST_BIT]) |=>
      !nack_r && cfg_r.acq_both == $past(wdata[CFG_MODE_BIT]))
    else $error("configuration word not stored");

  a_heater_follow: assert property (
    (data_wr && ptr_r == ADDR_CFG && !wdata[CFG_RST_BIT]) |=>
      heater_en_r == $past(wdata[CFG_HEAT_BIT]))
    else $error("heater enable does not follow bit 13");

  a_pointer_load: assert property (
    (ptr_wr && !srst_req) |=> ptr_r == $past(ptr_in) && nack_r ==
      !((($past(ptr_in)) <= ADDR_CFG) || ($past(ptr_in) >= ADDR_SN_HI)))
    else $error("pointer not loaded");

  a_reserved_zero: assert property (
    cfg_r.rsvd14 == 1'b0 && cfg_r.rsvd_low == 8'h00 && !cfg_r.soft_rst)
    else $error("reserved configuration bits set");

endmodule // hcr_regs

// *** tb/hcr_conv_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Converter model: answers each start with one done pulse unless a newer start restarts it
// ==========================================================
module hcr_conv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Conversion request from the block and chosen latency
  input wire hcr_pkg::hcr_conv_t conv,
  input wire logic [7:0] delay,
  // Completion pulse back to the block
  output logic conv_done
);
  import hcr_pkg::*;
  logic [7:0] cnt_r;
  logic run_r;
  // A new start restarts the count; done pulses once at its end.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv.start) begin
        run_r <= 1'b1;
        cnt_r <= delay;
      end else if (run_r && cnt_r == 8'h00) begin
        run_r <= 1'b0;
        conv_done <= 1'b1;
      end else if (run_r) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule // hcr_conv_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  bad_count++; $display("mismatch at %0t: got %h want %h", \
  $time, a, b); end end
module tb_top;
  import hcr_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam logic [39:0] SN = 40'hC3_9D41_6EB5; // Arbitrary value.
  logic clk, sys_rst, ptr_wr, data_wr, rd_req, low_supply_pin;
  logic conv_done, rd_valid_r, nack_r, busy_r, heater_en_r, soft_rst_r;
  logic [7:0] ptr_in, dly;
  logic [15:0] wdata, rd_data_r;
  logic tr;
  logic [1:0] hr;
  hcr_conv_t conv_r;
  int bad_count, checks_done;
  logic [2:0] starts[$];
  // Block under test and its converter.
  hcr_regs #(.SERIAL_NUM(SN)) hcr_regs_i (.clk(clk), .sys_rst(sys_rst),
    .ptr_wr(ptr_wr), .ptr_in(ptr_in), .data_wr(data_wr), .wdata(wdata),
    .rd_req(rd_req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .nack_r(nack_r), .low_supply_pin(low_supply_pin),
    .conv_done(conv_done), .conv_r(conv_r), .busy_r(busy_r),
    .heater_en_r(heater_en_r), .soft_rst_r(soft_rst_r));
  hcr_conv_model hcr_conv_model_i (.clk(clk), .sys_rst(sys_rst),
    .conv(conv_r), .delay(dly), .conv_done(conv_done));
  // ==========================================================
  // Clock, start log and watchdog
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Each start pulse is logged as {is_hum, res}.
  always @(negedge clk) begin
    if (conv_r.start === 1'b1) starts.push_back({conv_r.is_hum, conv_r.res});
  end
  initial begin
    #(50 * 20000);
    bad_count++;
    finish_test;
  end
  // ==========================================================
  // Access tasks
  // ==========================================================
  // One request cycle; answers stand in the following cycle.
  task automatic op(input logic [2:0] k, input logic [15:0] v);
    @(negedge clk);
    {ptr_wr, data_wr, rd_req} = k;
    ptr_in = v[7:0];
    wdata = v;
    @(negedge clk);
    {ptr_wr, data_wr, rd_req} = 3'b000;
  endtask
  task automatic wp(input logic [7:0] p, input logic nk);
    op(3'b100, {8'h00, p});
    `CHK(nack_r, nk)
  endtask
  task automatic wd(input logic [15:0] d, input logic nk);
    op(3'b010, d);
    `CHK(nack_r, nk)
  endtask
  task automatic rd(input logic [15:0] e, input logic vld);
    op(3'b001, 16'h0000);
    `CHK(rd_valid_r, vld)
    if (vld) `CHK(rd_data_r, e)
  endtask
  // Trigger, wait for the sequencer, then compare the start log.
  task automatic acq(input logic [7:0] p, input logic [2:0] e0,
                     input logic [2:0] e1, input int n);
    int i;
    starts.delete();
    wp(p, 1'b0);
    `CHK(busy_r, 1'b1)
    for (i = 0; i < 300 && busy_r !== 1'b0; i++) @(negedge clk);
    `CHK(busy_r, 1'b0)
    `CHK(starts.size(), n)
    if (starts.size() > 0) `CHK(starts[0], e0)
    if (n > 1 && starts.size() > 1) `CHK(starts[1], e1)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    {sys_rst, ptr_wr, data_wr, rd_req, low_supply_pin} = 5'b10000;
    ptr_in = 8'h00;
    wdata = 16'h0000;
    dly = 8'h02;
    bad_count = 0;
    checks_done = 0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    rd(16'h0000, 1'b0);
    wp(ADDR_CFG, 1'b0);
    rd(CFG_RESET, 1'b1);
    `CHK(heater_en_r, 1'b0)
    wp(ADDR_SN_HI, 1'b0);
    rd(SN[39:24], 1'b1);
    wd(16'hFFFF, 1'b1);
    rd(SN[39:24], 1'b1);
    wp(ADDR_SN_MID, 1'b0);
    rd(SN[23:8], 1'b1);
    wd(16'h0000, 1'b1);
    rd(SN[23:8], 1'b1);
    wp(ADDR_SN_LO, 1'b0);
    rd({SN[7:0], 8'h00}, 1'b1);
    wd(16'h00FF, 1'b1);
    rd({SN[7:0], 8'h00}, 1'b1);
    wp(8'h03, 1'b1);
    wd(16'h1234, 1'b1);
    wp(8'hFA, 1'b1);
    rd(16'h0000, 1'b0);
    // Reserved bits written as ones must read back zero.
    wp(ADDR_CFG, 1'b0);
    wd(16'h7FFF, 1'b0);
    rd(16'h3700, 1'b1);
    `CHK(heater_en_r, 1'b1)
    low_supply_pin = 1'b1;
    repeat (3) @(negedge clk);
    rd(16'h3F00, 1'b1);
    wd(16'h2000, 1'b0);
    rd(16'h2800, 1'b1);
    low_supply_pin = 1'b0;
    repeat (3) @(negedge clk);
    // Software reset restores defaults and the pointer.
    wd(16'hA000, 1'b0);
    `CHK(soft_rst_r, 1'b1)
    rd(16'h0000, 1'b0);
    wp(ADDR_CFG, 1'b0);
    rd(CFG_RESET, 1'b1);
    `CHK(heater_en_r, 1'b0)
    // Combined mode over humidity codes 00 to 10, fast with temperature code 0, slow with code 1.
    // Triggers come far faster than a host should pace them; the block
    // must not depend on that pacing, so it is not policed here.
    for (int i = 0; i < 6; i++) begin
      tr = (i >= 3);
      hr = 2'(i % 3);
      dly = (i >= 3) ? 8'h20 : 8'h01;
      wp(ADDR_CFG, 1'b0);
      wd({5'b00010, tr, hr, 8'h00}, 1'b0);
      acq(ADDR_TEMP, {2'b00, tr}, {1'b1, hr}, 2);
    end
    // Single mode converts only the named quantity.
    wp(ADDR_CFG, 1'b0);
    wd(16'h0600, 1'b0);
    acq(ADDR_TEMP, 3'b001, 3'b000, 1);
    acq(ADDR_HUM, 3'b110, 3'b000, 1);
    finish_test;
  end
endmodule // tb_top
